/* File: iqgo_defines.vh */
// Register indices, field positions, reset values and constants of the IQ gain, offset and coarse mixer block.
`ifndef IQGO_DEFINES_VH
`define IQGO_DEFINES_VH
`define IQGO_IDX_C_OFS      6'h0A
`define IQGO_IDX_D_OFS      6'h0B
`define IQGO_IDX_A_GAIN     6'h0C
`define IQGO_IDX_MIX_B_GAIN 6'h0D
`define IQGO_IDX_C_GAIN     6'h0E
`define IQGO_IDX_AB_PHASE   6'h10
`define IQGO_IDX_SYNC_EN    6'h1E
`define IQGO_IDX_STATUS     6'h1F
`define IQGO_OFS_MSB        12
`define IQGO_GAIN_MSB       10
`define IQGO_MIX_MSB        15
`define IQGO_MIX_LSB        12
`define IQGO_PHASE_MSB      11
`define IQGO_MIX_FS8        15
`define IQGO_MIX_FS4        14
`define IQGO_MIX_FS2        13
`define IQGO_MIX_NFS4       12
`define IQGO_SYNC_CD_BIT    0
`define IQGO_SYNC_AB_BIT    1
`define IQGO_OFS_RESET      13'h0000
`define IQGO_GAIN_RESET     11'h400
`define IQGO_MIX_RESET      4'h0
`define IQGO_PHASE_RESET    12'h000
`define IQGO_SYNC_RESET     2'h0
`define IQGO_GAIN_FRAC      10
`define IQGO_COS45          18'h05A82
`define IQGO_COS45_SHIFT    15
`define IQGO_POS_MAX        32'sh00007FFF
`define IQGO_NEG_MIN        -32'sh00008000
`endif

/* File: iqgo_fifo.v */
// Sample FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module iqgo_fifo #(
  parameter W     = 64,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          ce,
  input  wire          in_valid,
  input  wire [W-1:0]  in_data,
  output reg           in_ready,
  output wire          out_valid,
  output wire [W-1:0]  out_data,
  input  wire          out_ready,
  output wire [AW:0]   level
);
  reg  [W-1:0]  mem_q [0:DEPTH-1];
  reg  [AW-1:0] wr_q;
  reg  [AW-1:0] rd_q;
  reg  [AW:0]   cnt_q;
  wire          push;
  wire          pop;
  wire [AW:0]   cnt_d;
  integer       i;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  assign level     = cnt_q;
  assign cnt_d     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // The ready flag is registered so that it reflects the count after this edge.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_q     <= {AW{1'b0}};
      rd_q     <= {AW{1'b0}};
      cnt_q    <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      for (i = 0; i < DEPTH; i = i + 1)
        mem_q[i] <= {W{1'b0}};
    end
    else if (ce)
    begin
      if (push)
      begin
        mem_q[wr_q] <= in_data;
        wr_q        <= wr_q + 1'b1;
      end
      if (pop)
        rd_q <= rd_q + 1'b1;
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != DEPTH[AW:0]);
    end
  end
endmodule

/* File: iqgo_top.v */
// APB register file and coarse mixer for four sample channels, with gain correction on A, B and C and offset correction on C and D.
// What this block does
// - Channel D has a 13-bit offset word in bits 12:0 of its register, in converter LSBs, reset to zero.
// - Every gain word is an unsigned 11-bit multiplier from 0 to 1.9990 with ten fraction bits.
// - Channel A has its own gain word in bits 10:0 of its register, reset to unity, 0x400.
// - Channel B has its own gain word in bits 10:0 of the register that also holds the mixer field, reset to unity.
// - Channel C has its own gain word in bits 10:0 of its register, reset to unity.
// - The coarse mixer field in bits 15:12 resets to zero and selects fs/8, fs/4, fs/2 and minus fs/4 shifts.
// - Mixer bits set together add up to a total shift of plus or minus n times fs/8.
// - Unassigned bits reset to zero, read as zero and ignore written values.
// - With auto-sync on, a write to the channel C offset loads both C and D offsets together; a D write alone does not.
// - With auto-sync on, the A and B gains take effect only when the AB phase register is written.
`timescale 1ns/10ps
`include "iqgo_defines.vh"
module iqgo_top #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        in_valid,
  input  wire [63:0] in_data,
  output wire        in_ready,
  output reg         out_valid,
  output reg  [63:0] out_data,
  input  wire        out_ready
);
  reg  [12:0] channel_c_offset_word;
  reg  [12:0] channel_d_offset_word;
  reg  [10:0] channel_a_gain_word;
  reg  [10:0] channel_b_gain_word;
  reg  [10:0] channel_c_gain_word;
  reg  [3:0]  mix_mode_q;
  reg  [11:0] ab_phase_word;
  reg  [1:0]  sync_en_q;
  reg  [12:0] act_ofs_c_q;
  reg  [12:0] act_ofs_d_q;
  reg  [10:0] act_gain_a_q;
  reg  [10:0] act_gain_b_q;
  reg  [2:0]  mix_acc_q;
  reg         s1_valid_q;
  reg  [71:0] s1_data_q;
  reg  [31:0] rd_d;
  reg         hit_d;
  wire        fifo_valid;
  wire [63:0] fifo_data;
  wire [FIFO_AW:0] fifo_level;
  wire        adv;
  wire        take;
  wire        setup;
  wire        wr_en;
  wire [5:0]  idx;
  wire [2:0]  mix_step;
  wire [35:0] rot_ab;
  wire [35:0] rot_cd;

  // Rotates the pair (i, q) by m times 45 degrees.
  function [35:0] rotate;
    input [2:0]         m;
    input signed [17:0] i;
    input signed [17:0] q;
    reg signed [35:0] ti;
    reg signed [35:0] tq;
    reg signed [17:0] ri;
    reg signed [17:0] rq;
    begin
      ti = 36'sd0;
      tq = 36'sd0;
      ri = i;
      rq = q;
      if (m[0])
      begin
        ti = (i - q) * $signed(`IQGO_COS45);
        tq = (i + q) * $signed(`IQGO_COS45);
        ri = ti[17+`IQGO_COS45_SHIFT:`IQGO_COS45_SHIFT];
        rq = tq[17+`IQGO_COS45_SHIFT:`IQGO_COS45_SHIFT];
      end
      case (m[2:1])
        2'd1:    rotate = {-rq, ri};
        2'd2:    rotate = {-ri, -rq};
        2'd3:    rotate = {rq, -ri};
        default: rotate = {ri, rq};
      endcase
    end
  endfunction

  // Scales by an unsigned gain, adds a signed offset and saturates to 16 bits.
  function [15:0] correct;
    input signed [17:0] x;
    input [10:0]        g;
    input [12:0]        ofs;
    reg signed [31:0] p;
    reg signed [31:0] s;
    begin
      p = x * $signed({1'b0, g});
      s = (p >>> `IQGO_GAIN_FRAC) + $signed({{19{ofs[12]}}, ofs});
      if (s > `IQGO_POS_MAX)
        correct = 16'h7FFF;
      else if (s < `IQGO_NEG_MIN)
        correct = 16'h8000;
      else
        correct = s[15:0];
    end
  endfunction

  iqgo_fifo #(
    .W     (64),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .in_valid  (in_valid),
    .in_data   (in_data),
    .in_ready  (in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (take),
    .level     (fifo_level)
  );

  assign idx   = paddr[7:2];
  assign setup = psel & ~penable & ~pready;
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;

  // The mixer step sums fs/8 units of the enabled shifts modulo eight.
  assign mix_step = (mix_mode_q[`IQGO_MIX_FS8  - `IQGO_MIX_LSB] ? 3'd1 : 3'd0) +
                    (mix_mode_q[`IQGO_MIX_FS4  - `IQGO_MIX_LSB] ? 3'd2 : 3'd0) +
                    (mix_mode_q[`IQGO_MIX_FS2  - `IQGO_MIX_LSB] ? 3'd4 : 3'd0) +
                    (mix_mode_q[`IQGO_MIX_NFS4 - `IQGO_MIX_LSB] ? 3'd6 : 3'd0);

  // The pipeline moves when the output register is free or being drained.
  assign adv  = ~out_valid | out_ready;
  assign take = adv & (~s1_valid_q | adv) & fifo_valid;

  assign rot_ab = rotate(mix_acc_q, {{2{fifo_data[15]}}, fifo_data[15:0]},
                         {{2{fifo_data[31]}}, fifo_data[31:16]});
  assign rot_cd = rotate(mix_acc_q, {{2{fifo_data[47]}}, fifo_data[47:32]},
                         {{2{fifo_data[63]}}, fifo_data[63:48]});

  // Read data and address decode for the register file.
  always @*
  begin
    rd_d  = 32'h0000_0000;
    hit_d = 1'b1;
    case (idx)
      `IQGO_IDX_C_OFS:      rd_d = {19'h00000, channel_c_offset_word};
      `IQGO_IDX_D_OFS:      rd_d = {19'h00000, channel_d_offset_word};
      `IQGO_IDX_A_GAIN:     rd_d = {21'h000000, channel_a_gain_word};
      `IQGO_IDX_MIX_B_GAIN: rd_d = {16'h0000, mix_mode_q, 1'b0, channel_b_gain_word};
      `IQGO_IDX_C_GAIN:     rd_d = {21'h000000, channel_c_gain_word};
      `IQGO_IDX_AB_PHASE:   rd_d = {20'h00000, ab_phase_word};
      `IQGO_IDX_SYNC_EN:    rd_d = {30'h00000000, sync_en_q};
      `IQGO_IDX_STATUS:     rd_d = {23'h000000, s1_valid_q, fifo_valid, {(6-FIFO_AW){1'b0}}, fifo_level};
      default:              hit_d = 1'b0;
    endcase
  end

  // APB slave answers in the first cycle of the access phase.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready <= setup;
      if (setup)
      begin
        pslverr <= ~hit_d | (pwrite & (idx == `IQGO_IDX_STATUS));
        prdata  <= pwrite ? 32'h0000_0000 : rd_d;
      end
      else
      begin
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
      end
    end
  end

  // Software visible registers and the active copies used by the datapath.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel_c_offset_word <= `IQGO_OFS_RESET;
      channel_d_offset_word <= `IQGO_OFS_RESET;
      channel_a_gain_word   <= `IQGO_GAIN_RESET;
      channel_b_gain_word   <= `IQGO_GAIN_RESET;
      channel_c_gain_word   <= `IQGO_GAIN_RESET;
      mix_mode_q            <= `IQGO_MIX_RESET;
      ab_phase_word         <= `IQGO_PHASE_RESET;
      sync_en_q             <= `IQGO_SYNC_RESET;
      act_ofs_c_q           <= `IQGO_OFS_RESET;
      act_ofs_d_q           <= `IQGO_OFS_RESET;
      act_gain_a_q          <= `IQGO_GAIN_RESET;
      act_gain_b_q          <= `IQGO_GAIN_RESET;
    end
    else if (ce & wr_en)
    begin
      case (idx)
        `IQGO_IDX_C_OFS:
        begin
          channel_c_offset_word <= pwdata[`IQGO_OFS_MSB:0];
          if (sync_en_q[`IQGO_SYNC_CD_BIT])
          begin
            act_ofs_c_q <= pwdata[`IQGO_OFS_MSB:0];
            act_ofs_d_q <= channel_d_offset_word;
          end
        end
        `IQGO_IDX_D_OFS:      channel_d_offset_word <= pwdata[`IQGO_OFS_MSB:0];
        `IQGO_IDX_A_GAIN:     channel_a_gain_word <= pwdata[`IQGO_GAIN_MSB:0];
        `IQGO_IDX_MIX_B_GAIN:
        begin
          channel_b_gain_word <= pwdata[`IQGO_GAIN_MSB:0];
          mix_mode_q          <= pwdata[`IQGO_MIX_MSB:`IQGO_MIX_LSB];
        end
        `IQGO_IDX_C_GAIN:     channel_c_gain_word <= pwdata[`IQGO_GAIN_MSB:0];
        `IQGO_IDX_AB_PHASE:
        begin
          ab_phase_word <= pwdata[`IQGO_PHASE_MSB:0];
          if (sync_en_q[`IQGO_SYNC_AB_BIT])
          begin
            act_gain_a_q <= channel_a_gain_word;
            act_gain_b_q <= channel_b_gain_word;
          end
        end
        `IQGO_IDX_SYNC_EN:    sync_en_q <= pwdata[1:0];
        default:              sync_en_q <= sync_en_q;
      endcase
    end
  end

  // Stage one applies the coarse mixer, stage two the gain and offset.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mix_acc_q  <= 3'd0;
      s1_valid_q <= 1'b0;
      s1_data_q  <= 72'h0;
      out_valid  <= 1'b0;
      out_data   <= 64'h0;
    end
    else if (ce & adv)
    begin
      s1_valid_q <= fifo_valid;
      if (take)
      begin
        s1_data_q <= {rot_cd, rot_ab};
        mix_acc_q <= mix_acc_q + mix_step;
      end
      out_valid <= s1_valid_q;
      if (s1_valid_q)
      begin
        out_data[15:0]  <= correct(s1_data_q[35:18], act_gain_a_q, 13'h0000);
        out_data[31:16] <= correct(s1_data_q[17:0], act_gain_b_q, 13'h0000);
        out_data[47:32] <= correct(s1_data_q[71:54], channel_c_gain_word, act_ofs_c_q);
        out_data[63:48] <= correct(s1_data_q[53:36], `IQGO_GAIN_RESET, act_ofs_d_q);
      end
    end
  end
endmodule

/* File: iqgo_chk.sv */
// Concurrent checks on the register and stream ports of the IQ gain block.
`timescale 1ns/10ps
`include "iqgo_defines.vh"
module iqgo_chk #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input wire        pclk,
  input wire        presetn,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        in_valid,
  input wire [63:0] in_data,
  input wire        in_ready,
  input wire        out_valid,
  input wire [63:0] out_data,
  input wire        out_ready
);
  wire       rd = pready && !pwrite;
  wire [5:0] ix = paddr[7:2];
  a_setup_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && ce |=> pready) else $error("no ready after setup");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready && ce |=> !pready) else $error("ready longer than one cycle");
  a_ready_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pready) |-> $past(psel && !penable)) else $error("ready without setup");
  a_dofs_width: assert property (@(posedge pclk) disable iff (!presetn)
    rd && ix == `IQGO_IDX_D_OFS |-> prdata[31:13] == 19'h00000) else $error("offset upper bits set");
  a_again_width: assert property (@(posedge pclk) disable iff (!presetn)
    rd && ix == `IQGO_IDX_A_GAIN |-> prdata[31:11] == 21'h000000) else $error("gain A upper bits set");
  a_mixb_width: assert property (@(posedge pclk) disable iff (!presetn)
    rd && ix == `IQGO_IDX_MIX_B_GAIN |-> prdata[31:16] == 16'h0000 && !prdata[11]) else $error("bad mixer word");
  a_cgain_width: assert property (@(posedge pclk) disable iff (!presetn)
    rd && ix == `IQGO_IDX_C_GAIN |-> prdata[31:11] == 21'h000000) else $error("gain C upper bits set");
  a_err_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr |-> prdata == 32'h00000000) else $error("error read not zero");
  a_out_hold: assert property (@(posedge pclk) disable iff (!presetn)
    out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("output dropped");
  a_ce_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(out_valid) && $stable(in_ready)) else $error("state moved with ce low");
endmodule
bind iqgo_top iqgo_chk #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) i_iqgo_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
  .out_data(out_data), .out_ready(out_ready));

/* File: iq_gain_offset_coarse_mixer_test.sv */
// Self-checking bench of the IQ gain, offset and coarse mixer block.
`timescale 1ns/10ps
`include "iqgo_defines.vh"
module iq_gain_offset_coarse_mixer_test;
  reg         pclk, presetn, ce, psel, penable, pwrite, in_valid, out_ready;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  reg  [63:0] in_data, o1, o2;
  reg         er;
  wire [31:0] prdata;
  wire        pready, pslverr, in_ready, out_valid;
  wire [63:0] out_data;
  integer     err_total, n_tests, cyc, n, k, i;
  localparam [63:0]  S  = 64'h0040_0100_FF00_1234;
  localparam [23:0]  RI = {`IQGO_IDX_C_GAIN, `IQGO_IDX_MIX_B_GAIN, `IQGO_IDX_A_GAIN, `IQGO_IDX_D_OFS};
  localparam [127:0] RV = {32'h400, 32'h400, 32'h400, 32'h0};
  localparam [127:0] RM = {32'h7FF, 32'hF7FF, 32'h7FF, 32'h1FFF};
  iqgo_top #(.FIFO_DEPTH(16), .FIFO_AW(4)) i_iqgo_top (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task chk(input [63:0] seen, input [63:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [5:0] ix, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {ix, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task run(input [63:0] x, output [63:0] y);
    begin
      @(posedge pclk);
      in_valid <= 1'b1;
      in_data <= x;
      do @(posedge pclk); while (in_ready !== 1'b1);
      in_valid <= 1'b0;
      do @(posedge pclk); while (out_valid !== 1'b1);
      y = out_data;
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      end_of_test;
    end
  end
  initial
  begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    in_valid = 1'b0;
    in_data = 64'h0;
    out_ready = 1'b1;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    ce <= 1'b0;
    repeat (2) @(posedge pclk);
    ce <= 1'b1;
    for (i = 0; i < 4; i = i + 1)
    begin
      apb(1'b0, RI[i*6 +: 6], 32'h0);
      chk(rd, RV[i*32 +: 32]);
      apb(1'b1, RI[i*6 +: 6], 32'hFFFFFFFF);
      apb(1'b0, RI[i*6 +: 6], 32'h0);
      chk(rd, RM[i*32 +: 32]);
      apb(1'b1, RI[i*6 +: 6], RV[i*32 +: 32]);
    end
    apb(1'b0, 6'h3F, 32'h0);
    chk({rd, 31'h0, er}, {63'h0, 1'b1});
    run(S, o1);
    chk(o1, S);
    out_ready <= 1'b0;
    in_valid <= 1'b1;
    in_data <= S;
    n = 0;
    @(posedge pclk);
    while (in_ready === 1'b1)
    begin
      n = n + 1;
      @(posedge pclk);
    end
    in_valid <= 1'b0;
    apb(1'b0, `IQGO_IDX_STATUS, 32'h0);
    chk(rd[4:0], 5'h10);
    out_ready <= 1'b1;
    k = 0;
    repeat (40)
    begin
      @(posedge pclk);
      if (out_valid === 1'b1)
      begin
        k = k + 1;
        chk(out_data, S);
      end
    end
    chk(k, n);
    apb(1'b1, `IQGO_IDX_C_GAIN, 32'h200);
    run(S, o1);
    chk(o1, 64'h0040_0080_FF00_1234);
    apb(1'b1, `IQGO_IDX_C_GAIN, 32'h7FF);
    run(64'h0040_7000_FF00_1234, o1);
    chk(o1[47:32], 16'h7FFF);
    apb(1'b1, `IQGO_IDX_C_GAIN, 32'h400);
    apb(1'b1, `IQGO_IDX_MIX_B_GAIN, 32'h2400);
    run(S, o1);
    run(S, o2);
    chk({o1[31:16] + o2[31:16], o1[15:0] + o2[15:0]}, 32'h0);
    chk(o1[15:0] == 16'h1234 || o1[15:0] == 16'hEDCC, 1'b1);
    apb(1'b1, `IQGO_IDX_MIX_B_GAIN, 32'h5400);
    run(S, o1);
    chk(o1, S);
    apb(1'b1, `IQGO_IDX_MIX_B_GAIN, 32'h400);
    apb(1'b1, `IQGO_IDX_SYNC_EN, 32'h3);
    apb(1'b1, `IQGO_IDX_D_OFS, 32'h5);
    run(S, o1);
    chk(o1, S);
    apb(1'b1, `IQGO_IDX_C_OFS, 32'h1FFD);
    run(S, o1);
    chk(o1, 64'h0045_00FD_FF00_1234);
    apb(1'b1, `IQGO_IDX_A_GAIN, 32'h200);
    run(S, o1);
    chk(o1, 64'h0045_00FD_FF00_1234);
    apb(1'b1, `IQGO_IDX_AB_PHASE, 32'h0);
    run(S, o1);
    chk(o1, 64'h0045_00FD_FF00_091A);
    end_of_test;
  end
endmodule
